// ---- inc/piso_pkg.sv ----
/*
  package for the parallel-load shift register: widths, reset values,
  pin grouping struct and the synchroniser depth.
  assumes a single 25 MHz system clock and pins from outside that domain.
*/
package piso_pkg;
  localparam int unsigned STAGES       = 8;
  localparam int unsigned SYNC_DEPTH   = 2;
  localparam logic [7:0]  STAGE_RESET  = 8'h00;
  localparam logic        PIN_RESET    = 1'b0;
  localparam logic [2:0]  CTRL_RESET   = 3'h7; // idle: clocks high, no load
  // control pins sampled together
  typedef struct packed {
    logic shift_load_n;
    logic shift_clk;
    logic shift_hold;
  } ctrl_pins_t;
endpackage

// ---- design/pin_sync.sv ----
/*
  two-flop synchroniser for a bundle of asynchronous pins.
  assumes one clock, synchronous active-high reset and a clock enable.
*/
module pin_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic             ce_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  // first flop feeds only the second one
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_q   <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else if (ce_in) begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// ---- design/piso_shift8.sv ----
/*
  eight-stage parallel-in serial-out shift register, sampled on clk_in.
  assumes pin inputs are asynchronous to clk_in and that the far side
  holds each clock level for at least two clk_in periods; a shorter
  level may be missed, and pins are not watched while ce_in is low.
*/
module piso_shift8 #(
  parameter int unsigned WIDTH = piso_pkg::STAGES
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic             ce_in,
  input  wire logic             shift_load_n_in,
  input  wire logic             shift_clk_in,
  input  wire logic             shift_hold_in,
  input  wire logic             serial_in,
  input  wire logic [WIDTH-1:0] par_data_in,
  output logic                  serial_out,
  output logic                  serial_n_out
);
  piso_pkg::ctrl_pins_t ctrl_raw;
  piso_pkg::ctrl_pins_t ctrl_s;
  piso_pkg::ctrl_pins_t ctrl_prev_q;
  logic [WIDTH-1:0]     par_s;
  logic                 ser_s;
  logic [WIDTH-1:0]     stage_q;
  logic [WIDTH-1:0]     stage_d;
  logic                 clk_rise;
  logic                 hold_rise;
  logic                 do_shift;
  logic                 do_load;

  assign ctrl_raw = '{shift_load_n: shift_load_n_in,
                      shift_clk:    shift_clk_in,
                      shift_hold:   shift_hold_in};

  // every pin crosses two flops before any logic sees it
  pin_sync #(.WIDTH(3), .RESET_VAL(piso_pkg::CTRL_RESET)) u_ctrl_sync (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .ce_in    (ce_in),
    .async_in (ctrl_raw),
    .sync_out (ctrl_s)
  );
  pin_sync #(.WIDTH(WIDTH + 1)) u_data_sync (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .ce_in    (ce_in),
    .async_in ({serial_in, par_data_in}),
    .sync_out ({ser_s, par_s})
  );

  // previous sample of control pins for edge detection; its reset value
  // is all high, so a pin idling low shows a fall, never a false rise
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ctrl_prev_q <= piso_pkg::CTRL_RESET;
    end else if (ce_in) begin
      ctrl_prev_q <= ctrl_s;
    end
  end

  // edge seen once per sample, so one edge gives one shift
  assign clk_rise  = ctrl_s.shift_clk & ~ctrl_prev_q.shift_clk;
  assign hold_rise = ctrl_s.shift_hold & ~ctrl_prev_q.shift_hold;
  assign do_load   = ~ctrl_s.shift_load_n;
  // the two clock inputs are interchangeable
  // a simultaneous rise of both counts as no shift: neither is low
  assign do_shift  = ctrl_s.shift_load_n &
                     ((clk_rise & ~ctrl_s.shift_hold) |
                      (hold_rise & ~ctrl_s.shift_clk));

  // decode checks; the shift decision looks only at synced samples
  property p_clk_edge;
    @(posedge clk_in) disable iff (rst_in)
      (clk_rise && !ctrl_s.shift_hold && ctrl_s.shift_load_n) |-> do_shift;
  endproperty
  a_clk_edge: assert property (p_clk_edge)
    else $error("clock rise with inhibit low did not shift");

  // held high means high in this sample and in the one before
  property p_held_high;
    @(posedge clk_in) disable iff (rst_in)
      ((ctrl_s.shift_clk && ctrl_prev_q.shift_clk) ||
       (ctrl_s.shift_hold && ctrl_prev_q.shift_hold)) |-> !do_shift;
  endproperty
  a_held_high: assert property (p_held_high)
    else $error("shift while a clock input was held high");

  property p_no_shift_high;
    @(posedge clk_in) disable iff (rst_in)
      (ctrl_s.shift_hold && ctrl_s.shift_clk) |-> !do_shift;
  endproperty
  a_no_shift_high: assert property (p_no_shift_high)
    else $error("shift while a clock input was high");

  property p_hold_edge;
    @(posedge clk_in) disable iff (rst_in)
      (hold_rise && !ctrl_s.shift_clk && ctrl_s.shift_load_n) |-> do_shift;
  endproperty
  a_hold_edge: assert property (p_hold_edge)
    else $error("hold rise with clock low did not shift");

  property p_load_wins;
    @(posedge clk_in) disable iff (rst_in)
      do_load |-> !do_shift;
  endproperty
  a_load_wins: assert property (p_load_wins)
    else $error("shift while parallel load was held");

  // a rise must clear after one use, or a held level would repeat
  property p_one_shift;
    @(posedge clk_in) disable iff (rst_in)
      (ce_in && clk_rise) |=> !clk_rise;
  endproperty
  a_one_shift: assert property (p_one_shift)
    else $error("one clock rise seen twice");

  // same guard for the inhibit path
  property p_hold_once;
    @(posedge clk_in) disable iff (rst_in)
      (ce_in && hold_rise) |=> !hold_rise;
  endproperty
  a_hold_once: assert property (p_hold_once)
    else $error("one inhibit rise seen twice");

  // next stage contents; stage 0 is first, WIDTH-1 is last
  always_comb begin
    stage_d = stage_q;
    // load first: it overrides any clock activity
    if (do_load) begin
      stage_d = par_s;
    end else if (do_shift) begin
      stage_d = {stage_q[WIDTH-2:0], ser_s};
    end
    // otherwise hold, parallel inputs ignored
  end

  // reset value is a tidy zero, but users must not rely on it
  // stage_d also feeds the output flops, so both move on one edge
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      stage_q <= piso_pkg::STAGE_RESET[WIDTH-1:0];
    end else if (ce_in) begin
      stage_q <= stage_d;
    end
  end

  // stage update checks
  property p_load_follows;
    @(posedge clk_in) disable iff (rst_in)
      (ce_in && do_load) |=> (stage_q == $past(par_s));
  endproperty
  a_load_follows: assert property (p_load_follows)
    else $error("stages did not take parallel data");

  property p_hold_stable;
    @(posedge clk_in) disable iff (rst_in)
      (ce_in && !do_load && !do_shift) |=> $stable(stage_q);
  endproperty
  a_hold_stable: assert property (p_hold_stable)
    else $error("stages changed without load or shift");

  property p_shift_move;
    @(posedge clk_in) disable iff (rst_in)
      (ce_in && do_shift) |=>
        (stage_q[WIDTH-1:1] == $past(stage_q[WIDTH-2:0]));
  endproperty
  a_shift_move: assert property (p_shift_move)
    else $error("stages did not move toward the last");

  property p_shift_in;
    @(posedge clk_in) disable iff (rst_in)
      (ce_in && do_shift) |=> (stage_q[0] == $past(ser_s));
  endproperty
  a_shift_in: assert property (p_shift_in)
    else $error("first stage missed serial input");

  // one check per stage, so a crossed data wire names its own stage;
  // the whole-word check above cannot say which stage went wrong
  for (genvar i = 0; i < WIDTH; i++) begin : g_take_chk
    property p_stage_take;
      @(posedge clk_in) disable iff (rst_in)
        (ce_in && do_load) |=> (stage_q[i] == $past(par_s[i]));
    endproperty
    a_stage_take: assert property (p_stage_take)
      else $error("a stage missed its own parallel input");
  end

  // outputs take the next last stage, so they move with it
  // driving them from stage_q instead would lag the stages by one edge
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      serial_out   <= piso_pkg::PIN_RESET;
      serial_n_out <= ~piso_pkg::PIN_RESET;
    end else if (ce_in) begin
      serial_out   <= stage_d[WIDTH-1];
      serial_n_out <= ~stage_d[WIDTH-1];
    end
  end

  // output pair check
  property p_outputs;
    @(posedge clk_in) disable iff (rst_in)
      ##1 ((serial_out == stage_q[WIDTH-1]) &&
           (serial_n_out != serial_out));
  endproperty
  a_outputs: assert property (p_outputs)
    else $error("serial outputs disagree with last stage");
endmodule

// ---- verification/ctrl_model.sv ----
/*
  controller model that drives the shift register pins.
  assumes the bench calls drive() and that pins change on falling edges.
*/
module ctrl_model (
  input  wire logic       clk_in,
  output logic            load_n_out,
  output logic            sclk_out,
  output logic            hold_out,
  output logic            data_out,
  output logic [7:0]      par_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle with load high and clock high, so the first clock fall cannot shift
  initial begin
    load_n_out = 1'b1;
    sclk_out   = 1'b1;
    hold_out   = 1'b0;
    data_out   = 1'b0;
    par_out    = 8'h00;
  end
  // each level is held three cycles; the design needs two to see it
  task automatic drive(input logic l, c, h, s, input logic [7:0] p);
    @(negedge clk_in);
    load_n_out = l;
    sclk_out   = c;
    hold_out   = h;
    data_out   = s;
    par_out    = p;
    repeat (3) @(posedge clk_in);
  endtask
endmodule

// ---- verification/tb.sv ----
/*
  self-checking bench for the eight-stage shift register.
  assumes the answer lands three edges after a pin change.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0, rst_in = 1'b1, ce = 1'b1;
  logic ld, sc, hd, sd, so, son;
  logic [7:0] pd, m, p;
  logic q[$];
  int fail_count = 0, checks = 0, cycles = 0;
  event look;
  initial forever #20 clk_in = ~clk_in;
  ctrl_model u_ctrl_model (.clk_in(clk_in), .load_n_out(ld), .sclk_out(sc),
    .hold_out(hd), .data_out(sd), .par_out(pd));
  piso_shift8 u_piso_shift8 (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce),
    .shift_load_n_in(ld), .shift_clk_in(sc), .shift_hold_in(hd),
    .serial_in(sd), .par_data_in(pd), .serial_out(so), .serial_n_out(son));
  task automatic close_out();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmp(input string n, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %b seen %b", n, e, g);
    end
  endtask
  // note the expected last stage, then let the watcher look
  task automatic step(input logic l, c, h, s, input logic [7:0] d);
    u_ctrl_model.drive(l, c, h, s, d);
    q.push_back(m[7]);
    @(negedge clk_in);
    ->look;
  endtask
  // one shift through the clock or, with clock low, through the inhibit
  task automatic sh(input logic s, input logic via_hold);
    step(1'b1, 1'b0, 1'b0, s, p);
    m = {m[6:0], s};
    if (via_hold) begin
      step(1'b1, 1'b0, 1'b1, s, p);
      step(1'b1, 1'b1, 1'b1, s, p);
    end
    step(1'b1, 1'b1, 1'b0, s, p);
  endtask
  // watcher compares the oldest note against both outputs
  initial forever begin
    @(look);
    cmp("serial_out", q[0], so);
    cmp("serial_n_out", ~q.pop_front(), son);
  end
  // hang guard
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      close_out();
    end
  end
  initial begin
    void'($urandom(41195));
    m = 8'h00;
    p = 8'h00;
    repeat (8) @(posedge clk_in);
    @(negedge clk_in) rst_in = 1'b0;
    repeat (3) @(posedge clk_in);
    for (int i = 0; i < 4; i++) begin
      m = 8'($urandom);
      step(1'b0, 1'b1, 1'b0, 1'b0, m);
      for (int j = 0; j < 9; j++) begin
        p = 8'($urandom);
        sh(1'($urandom), j[0]);
      end
    end
    // clock and inhibit edges while loading change nothing but the load
    m = 8'h55;
    step(1'b0, 1'b0, 1'b1, 1'b1, m);
    step(1'b0, 1'b1, 1'b0, 1'b1, m);
    m = 8'haa;
    step(1'b0, 1'b1, 1'b0, 1'b0, m);
    // clock rise while inhibited must not shift
    step(1'b1, 1'b1, 1'b1, 1'b1, 8'h00);
    step(1'b1, 1'b0, 1'b1, 1'b1, 8'h00);
    step(1'b1, 1'b1, 1'b1, 1'b1, 8'h00);
    step(1'b1, 1'b1, 1'b0, 1'b1, 8'h00);
    // enable low stops sampling, so a clock pulse inside it is lost
    @(negedge clk_in) ce = 1'b0;
    step(1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
    step(1'b1, 1'b1, 1'b0, 1'b0, 8'h00);
    ce = 1'b1;
    step(1'b1, 1'b1, 1'b0, 1'b0, 8'h00);
    // let the watcher finish the last comparison
    @(posedge clk_in);
    close_out();
  end
endmodule
